// ---- adc_channel_and_conversion_control.sv ----
// Converter control register with APB access and conversion sequencer
//
// Local design decisions: the register addresses and the APB interface to the registers.
`include "adc_ctrl_consts.svh"

// Operation
// - Writing trigger one with power already on starts conversion
// - Trigger reads one while converting
// - Hardware clears trigger when conversion ends
// - Codes 00100 to 11100 connect nothing
// - Clearing trigger aborts, stores partial result
module adc_channel_and_conversion_control
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_BITS = `CONV_BITS,
	parameter int BIT_TIME_NS = `BIT_TIME_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic comparator_out,
	output logic sample_hold,
	output logic converter_power_on,
	output source_t source_sel,
	output logic conversion_done
);

	// ==========================================================
	// Timing and counter widths
	// Cycles per converted bit, rounded down, at least one
	// Rounding down makes each bit a little shorter than asked; a slow
	// clock against a short bit time still gets one cycle per bit
	localparam int BIT_CYC_RAW = BIT_TIME_NS / `CLK_PERIOD_NS;
	localparam int BIT_CYC = (BIT_CYC_RAW < 1) ? 1 : BIT_CYC_RAW;
	localparam int CW = $clog2(BIT_CYC + 1);
	localparam int BW = $clog2(CONV_BITS + 1);

	// ==========================================================
	// State
	typedef struct packed {
		conv_state_t st;
		logic [4:0] sel;
		logic power;
		logic trigger;
		logic [CONV_BITS-1:0] sar;
		logic [CONV_BITS-1:0] result;
		logic [BW-1:0] bit_idx;
		logic [CW-1:0] cyc;
		logic last_bit;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic hold;
		logic done;
	} ctl_state_t;

	ctl_state_t s_reg;
	ctl_state_t s_next;

	// ==========================================================
	// Bus decode
	// Access phase decode; the ready term stops a second take of the
	// same transfer in the cycle where the answer stands
	logic acc;
	logic hit_ctrl;
	logic hit_res;
	assign acc = psel && penable && !s_reg.ready;
	assign hit_ctrl = paddr == `CTRL_OFFSET;
	assign hit_res = paddr == `RESULT_OFFSET;

	// ==========================================================
	// Helpers
	// Partial result: unconverted bits copy the last resolved bit
	// Bits at and below the trial position are not yet resolved
	function automatic logic [CONV_BITS-1:0] fill_partial(
		input logic [CONV_BITS-1:0] v,
		input logic [BW-1:0] idx,
		input logic lastb
	);
		logic [CONV_BITS-1:0] r;
		r = v;
		for (int i = 0; i < CONV_BITS; i++) begin
			if (i <= int'(idx)) begin
				r[i] = lastb;
			end
		end
		return r;
	endfunction : fill_partial

	// Control byte as software sees it
	function automatic logic [7:0] ctrl_byte(input ctl_state_t s);
		logic [7:0] b;
		b = 8'h00;
		b[`SELECT_MSB:`SELECT_LSB] = s.sel;
		b[`TRIGGER_BIT] = s.trigger;
		b[`POWER_BIT] = s.power;
		return b;
	endfunction : ctrl_byte

	// ==========================================================
	// Next-state logic: bus slave and successive approximation
	always_comb begin
		// Hold every field by default
		s_next = s_reg;
		// Answer, error and completion are one-cycle pulses
		s_next.ready = 1'b0;
		s_next.err = 1'b0;
		s_next.done = 1'b0;
		// Bus access: one wait state, answer in the second access cycle
		if (acc) begin
			s_next.ready = 1'b1;
			if (!pwrite) begin
				if (hit_ctrl) begin
					s_next.rdata = {24'h0, ctrl_byte(s_reg)};
				end else if (hit_res) begin
					s_next.rdata = 32'(s_reg.result);
				end else begin
					s_next.rdata = 32'h0;
					s_next.err = 1'b1;
				end
			end else if (hit_ctrl) begin
				if (pstrb[0]) begin
					s_next.sel = pwdata[`SELECT_MSB:`SELECT_LSB];
					s_next.power = pwdata[`POWER_BIT];
					s_next.trigger = pwdata[`TRIGGER_BIT];
				end
			end else if (!hit_res) begin
				s_next.err = 1'b1;
			end
		end
		// Sequencer
		unique case (s_reg.st)
			ST_IDLE: begin
				// Trigger without power is ignored; software powers first
				if (s_next.trigger && !s_reg.trigger) begin
					if (s_reg.power) begin
						s_next.st = ST_CONV;
						s_next.hold = 1'b1;
						s_next.sar = '0;
						s_next.sar[CONV_BITS-1] = 1'b1;
						s_next.bit_idx = BW'(CONV_BITS - 1);
						s_next.cyc = '0;
						// A fresh run must not inherit the old last bit
						s_next.last_bit = 1'b0;
					end else begin
						// Dropped: the bit reads back zero
						s_next.trigger = 1'b0;
					end
				end
			end
			ST_CONV: begin
				if (!s_next.trigger || !s_next.power) begin
					// Abort: store what was resolved so far
					s_next.result = fill_partial(s_reg.sar,
						s_reg.bit_idx, s_reg.last_bit);
					s_next.trigger = 1'b0;
					s_next.hold = 1'b0;
					s_next.st = ST_IDLE;
				end else if (s_reg.cyc == CW'(BIT_CYC - 1)) begin
					// End of a bit period: keep the comparator answer
					s_next.cyc = '0;
					s_next.sar[s_reg.bit_idx] = comparator_out;
					s_next.last_bit = comparator_out;
					if (s_reg.bit_idx == '0) begin
						s_next.st = ST_DONE;
					end else begin
						s_next.sar[s_reg.bit_idx - 1'b1] = 1'b1;
						s_next.bit_idx = s_reg.bit_idx - 1'b1;
					end
				end else begin
					// Still inside the bit period
					s_next.cyc = s_reg.cyc + 1'b1;
				end
			end
			ST_DONE: begin
				// Last bit settled: publish the result, drop the flag
				s_next.result = s_reg.sar;
				s_next.trigger = 1'b0;
				s_next.hold = 1'b0;
				s_next.done = 1'b1;
				s_next.st = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{st: ST_IDLE, rdata: 32'h0, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Analog source steering
	// The source follows the register one cycle late; software should
	// let it settle before starting a run on a new input
	adc_input_mux u_mux (
		.pclk(pclk),
		.presetn(presetn),
		.input_select_field(s_reg.sel),
		.converter_power_on(s_reg.power),
		.source_sel(source_sel)
	);

	// ==========================================================
	// Outputs, each straight from a flip-flop
	assign prdata = s_reg.rdata;
	assign pready = s_reg.ready;
	assign pslverr = s_reg.err;
	assign sample_hold = s_reg.hold;
	assign converter_power_on = s_reg.power;
	assign conversion_done = s_reg.done;

endmodule : adc_channel_and_conversion_control

// ---- adc_ctrl_consts.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// ==========================================================
// Register map (byte addresses)
`define CTRL_OFFSET 12'h000
`define RESULT_OFFSET 12'h004
`define ADDR_W 12

// ==========================================================
// Control register fields
`define POWER_BIT 0
`define TRIGGER_BIT 1
`define SELECT_LSB 2
`define SELECT_MSB 6
`define CTRL_RESET 8'h00

// ==========================================================
// Input select codes
`define SEL_RESERVED_LO 5'h04
`define SEL_RESERVED_HI 5'h1c
`define SEL_TEMP 5'h1d
`define SEL_DAC 5'h1e
`define SEL_FIXED_REF 5'h1f

// ==========================================================
// Conversion timing
`define CONV_BITS 10
`define BIT_TIME_NS 1000
`define CLK_PERIOD_NS 4

`endif

// ---- adc_ctrl_pkg.sv ----
// Types shared by the converter control block
package adc_ctrl_pkg;

	// ==========================================================
	// Conversion sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_DONE = 3'b100
	} conv_state_t;

	// ==========================================================
	// Analog source picked by the select field
	typedef enum logic [7:0] {
		SRC_NONE = 8'h00,
		SRC_AN0 = 8'h01,
		SRC_AN1 = 8'h02,
		SRC_AN2 = 8'h04,
		SRC_AN3 = 8'h08,
		SRC_TEMP = 8'h10,
		SRC_DAC = 8'h20,
		SRC_FREF = 8'h40
	} source_t;

endpackage : adc_ctrl_pkg

// ---- adc_input_mux.sv ----
// Input select decoder that steers the analog multiplexer
`include "adc_ctrl_consts.svh"

module adc_input_mux
	import adc_ctrl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [4:0] input_select_field,
	input wire logic converter_power_on,
	output source_t source_sel
);

	// ==========================================================
	// State
	typedef struct packed {
		source_t src;
	} mux_state_t;

	mux_state_t s_reg;
	mux_state_t s_next;

	// Decode code to one-hot source; powered-off converter sees nothing
	always_comb begin
		s_next = s_reg;
		if (!converter_power_on) begin
			s_next.src = SRC_NONE;
		end else if (input_select_field >= `SEL_RESERVED_LO &&
			input_select_field <= `SEL_RESERVED_HI) begin
			s_next.src = SRC_NONE;
		end else begin
			unique case (input_select_field)
				5'h00: s_next.src = SRC_AN0;
				5'h01: s_next.src = SRC_AN1;
				5'h02: s_next.src = SRC_AN2;
				5'h03: s_next.src = SRC_AN3;
				`SEL_TEMP: s_next.src = SRC_TEMP;
				`SEL_DAC: s_next.src = SRC_DAC;
				default: s_next.src = SRC_FREF;
			endcase
		end
	end

	// Register so the mux select is glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{src: SRC_NONE};
		end else begin
			s_reg <= s_next;
		end
	end

	assign source_sel = s_reg.src;

endmodule : adc_input_mux

// ---- adc_core_model.sv ----
// Behavioural analog core behind the converter control block
module adc_core_model
	import adc_ctrl_pkg::*;
(
	input wire logic sample_hold,
	input wire source_t source_sel,
	output logic comparator_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Input one sits at full scale, every other source at zero
	always_comb begin
		comparator_out = sample_hold && source_sel == SRC_AN1;
	end
endmodule : adc_core_model

// ---- adc_ctl_chk.sv ----
// Port assertions for the converter control block
`include "adc_ctrl_consts.svh"
module adc_ctl_chk
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_BITS = 10,
	parameter int BIT_TIME_NS = 1000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sample_hold,
	input wire logic converter_power_on,
	input wire source_t source_sel,
	input wire logic conversion_done
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cycles a full conversion should take
	localparam int N = CONV_BITS * (BIT_TIME_NS / `CLK_PERIOD_NS);
	logic [15:0] cnt;
	// ==========
	// Length of the last run, held after it ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt <= '0;
		else if (sample_hold)
			cnt <= $rose(sample_hold) ? 16'h0001 : cnt + 16'h0001;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_go_wr;
		psel && penable && pwrite && paddr == 0 && pstrb[0] && pwdata[1];
	endsequence
	sequence s_armed;
		converter_power_on && !sample_hold;
	endsequence
	// Answer to a control read whose take saw a run in progress
	sequence s_busy_rd;
		pready && !pwrite && paddr == 0 && $past(sample_hold);
	endsequence
	// Control write taken with a reserved select code
	sequence s_rsv_wr;
		psel && penable && !pready && pwrite && paddr == 0 && pstrb[0] &&
			pwdata[`SELECT_MSB:`SELECT_LSB] >= `SEL_RESERVED_LO &&
			pwdata[`SELECT_MSB:`SELECT_LSB] <= `SEL_RESERVED_HI;
	endsequence
	// ==========
	a_go_starts: assert property (s_go_wr and s_armed |-> ##[1:3] sample_hold)
		else $error("start missed");
	a_busy_reads: assert property (s_busy_rd |-> prdata[1])
		else $error("busy flag reads zero");
	a_rsv_none: assert property (s_rsv_wr |-> ##2 source_sel == SRC_NONE)
		else $error("reserved code routed a source");
	a_done_len: assert property (conversion_done |-> cnt >= N && cnt <= N + 2)
		else $error("bad run length");
	a_done_pulse: assert property (conversion_done |=> !conversion_done)
		else $error("done too long");
	a_src_onehot: assert property ($onehot0(source_sel))
		else $error("two sources");
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no ready");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_map: assert property (pready && paddr > 12'h004 |-> pslverr)
		else $error("no slave error");
	a_top_zero: assert property (pready && !pwrite && paddr == 0 |-> prdata[31:7] == 0)
		else $error("upper bits set");
endmodule : adc_ctl_chk
bind adc_channel_and_conversion_control adc_ctl_chk #(
	.CONV_BITS(CONV_BITS),
	.BIT_TIME_NS(BIT_TIME_NS)
) u_chk (.*);

// ---- tb_top.sv ----
// Register level testbench for the converter control block
`include "adc_ctrl_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_ctrl_pkg::*;
	logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rv;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, comparator_out, sample_hold;
	logic converter_power_on, conversion_done;
	source_t source_sel;
	int fails = 0, tests_run = 0;
	// Short bit time keeps a conversion near twenty cycles
	adc_channel_and_conversion_control #(.BIT_TIME_NS(8)) u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.comparator_out(comparator_out),
		.sample_hold(sample_hold),
		.converter_power_on(converter_power_on),
		.source_sel(source_sel),
		.conversion_done(conversion_done)
	);
	adc_core_model u_core (
		.sample_hold(sample_hold),
		.source_sel(source_sel),
		.comparator_out(comparator_out)
	);
	// Completion pulses, counted mid-cycle where the pulse has settled
	int done_seen = 0;
	always @(negedge pclk) begin
		if (conversion_done === 1'b1)
			done_seen++;
	end
	initial begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	// ==========
	// One APB transfer; read data and error kept in rv and err
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look mid-cycle, where the answer has settled and still stands
		@(negedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(negedge pclk);
		end
		rv = prdata;
		err = pslverr;
		// The next rising edge samples the answer; release after it
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			fails++;
	endtask : apb
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Poll the trigger bit, bounded
	task automatic poll();
		for (int n = 0; n < 50; n++) begin
			apb(0, 0, 0);
			if (rv[1] !== 1'b1)
				break;
		end
	endtask : poll
	function automatic source_t exp_src(input logic [4:0] c);
		case (c)
			5'h00: return SRC_AN0;
			5'h01: return SRC_AN1;
			5'h02: return SRC_AN2;
			5'h03: return SRC_AN3;
			`SEL_TEMP: return SRC_TEMP;
			`SEL_DAC: return SRC_DAC;
			`SEL_FIXED_REF: return SRC_FREF;
			default: return SRC_NONE;
		endcase
	endfunction : exp_src
	task automatic print_verdict();
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	// ==========
	// Watchdog against a hung handshake or conversion
	initial begin
		#50000;
		fails++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 0, 0);
		chk(rv, 32'h0);
		apb(1, 12'h040, 32'h1);
		chk({31'h0, err}, 32'h1);
		apb(1, 0, 32'h2);
		apb(0, 0, 0);
		chk(rv, 32'h0);
		// Every select code, with the converter powered
		for (int c = 0; c < 32; c++) begin
			apb(1, 0, {25'h0, c[4:0], 2'b01});
			repeat (2) @(posedge pclk);
			chk({24'h0, source_sel}, {24'h0, exp_src(c[4:0])});
		end
		// Full scale run, then zero run, then an aborted run
		apb(1, 0, 32'h05);
		chk({31'h0, converter_power_on}, 32'h1);
		apb(1, 0, 32'h07);
		apb(0, 0, 0);
		chk(rv, 32'h07);
		poll();
		chk(rv, 32'h05);
		apb(0, `RESULT_OFFSET, 0);
		chk(rv, 32'h3ff);
		chk(done_seen, 1);
		apb(1, 0, 32'h01);
		apb(1, 0, 32'h03);
		poll();
		apb(0, `RESULT_OFFSET, 0);
		chk(rv, 32'h0);
		chk(done_seen, 2);
		apb(1, 0, 32'h05);
		apb(1, 0, 32'h07);
		repeat (8) @(posedge pclk);
		apb(1, 0, 32'h05);
		apb(0, 0, 0);
		chk(rv, 32'h05);
		apb(0, `RESULT_OFFSET, 0);
		chk(rv, 32'h3ff);
		chk(done_seen, 2);
		print_verdict();
	end
endmodule : tb_top
